// *** hdl/mrop_pkg.sv ***
package mrop_pkg;
  // Header contents.
  localparam logic [7:0] SYNC_BYTE = 8'h80;
  localparam logic [2:0] PKG_FIRST = 3'h0;
  localparam logic [2:0] PKG_LAST = 3'h5;
  localparam logic [2:0] PKG_CAL = 3'h6;
  localparam logic [2:0] PKG_PF = 3'h7;
  localparam logic [2:0] PKG_E1 = 3'h3;
  localparam logic [2:0] PKG_E2 = 3'h4;
  // Byte counts of the three kinds of transfer.
  localparam logic [4:0] HDR_BYTES = 5'h04;
  localparam logic [4:0] PKG_BYTES = 5'h10;
  localparam logic [4:0] PF_BYTES = 5'h1C;
  // Slot timing in clock cycles.
  localparam int LEAD_CYC = 11;
  localparam int TAIL_CYC = 12;
  localparam int SLOT_CYC = 11;
  localparam int HDR_GAP_CYC = 11;
  localparam int PF_GAP_CYC = 16;
  localparam logic [8:0] MAX_PKG_CYC = 9'h12C;
  // Package schedule.
  localparam int CLK_HZ = 10000000;
  localparam int PKG_PERIOD_MS = 200;
  localparam int LINE_GAP_MS = 20;
  localparam int PKG_PERIOD_CYC = PKG_PERIOD_MS * (CLK_HZ / 1000);
  localparam int LINE_GAP_CYC = LINE_GAP_MS * (CLK_HZ / 1000);
  // Ten percent of the unsigned full-scale voltage.
  localparam logic [15:0] VP_THRESH = 16'h1999;
  localparam logic [1:0] CAL_RETRIES = 2'h2;
  // Status bus bit positions, bit 0 is B8.
  localparam int ST_TAMPER_FLAG = 7;
  localparam int ST_BELOW_STARTING_CURRENT_FLAG = 6;
  localparam int ST_VP1 = 5;
  localparam int ST_VP2 = 4;
  localparam int ST_VP3 = 3;
  localparam int ST_ERR = 2;
  localparam int ST_DR = 1;
  localparam int ST_INI = 0;
  // Output buffer shape.
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;
  typedef enum logic [1:0] {
    K_NORM = 2'b00, K_CAL = 2'b01, K_PF = 2'b10
  } mrop_kind_t;
  typedef enum logic [1:0] {
    B_IDLE = 2'b00, B_HDR = 2'b01, B_PAY = 2'b10
  } mrop_bld_t;
  typedef enum logic [1:0] {
    T_IDLE = 2'b00, T_RUN = 2'b01, T_TAIL = 2'b10
  } mrop_tx_t;
endpackage

// *** hdl/mrop_top.sv ***
// How it works
// - Normal package number 0..5 in first byte.
// - Number six while waiting for calibration.
// - Number seven announces back-to-back energy packages.
// - Second header byte is always 80H.
// - Fourth header byte equals status bus.
// - Data-ready pulse with address line zero.
// - Unstalled package completes within 200 clocks.
// - Ready 11 before first, drops 12 after.
// - Measurement bytes every 11th clock.
// - Address line one high during bus use.
// - Bus-ready high holds the device writing.
// - Processor samples on strobe, low when idle.
// - Status bus bit layout B15 to B8.
// - Voltage flags follow ten percent threshold.
// - Error flag on any listed fault.
// - Retry coefficient read twice, then defaults.
// - Power fail sends packages 3, 4 at the next idle point, ahead of all else.
// - Sixteen clocks between blocks, no header repeat.
// - Starting-current flag when all currents low.
// - Tamper flag on zero or negative current.
// - Package is four header, twelve data bytes.
// - Six packages per 200 ms period.
`timescale 1ns/1ns
module mrop_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } mrop_fifo_t;
  mrop_fifo_t s_r, s_nxt;
  logic full;
  logic empty;

  // The extra pointer bit tells a full buffer from an empty one.
  assign empty = s_r.wp == s_r.rp;
  assign full = (s_r.wp[AW] != s_r.rp[AW]) &&
                (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = s_r.mem[s_r.rp[AW-1:0]];

  // Write and read advance independently.
  always_comb begin
    s_nxt = s_r;
    if (in_valid && !full) begin
      s_nxt.mem[s_r.wp[AW-1:0]] = in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
  end

  // Register the buffer state.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

module mrop_top #(
  parameter int PERIOD_CYC = mrop_pkg::PKG_PERIOD_CYC,
  parameter int GAP_CYC = mrop_pkg::LINE_GAP_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic supply_break_input,
  input wire logic bus_ready_stall_input,
  input wire logic init_active,
  input wire logic [7:0] mode_byte,
  input wire logic [15:0] phase1_volt,
  input wire logic [15:0] phase2_volt,
  input wire logic [15:0] phase3_volt,
  input wire logic [15:0] phase1_curr,
  input wire logic [15:0] phase2_curr,
  input wire logic [15:0] phase3_curr,
  input wire logic [15:0] start_level,
  input wire logic link_fault,
  input wire logic internal_fault,
  input wire logic err_clear,
  input wire logic cal_request,
  input wire logic cal_check_done,
  input wire logic cal_check_bad,
  input wire logic cal_timeout,
  input wire logic pay_valid,
  input wire logic [7:0] pay_data,
  output logic pay_ready,
  output logic [2:0] pay_pkg,
  output logic [7:0] data_bus_out,
  output logic data_bus_oe,
  output logic strobe,
  output logic address_line_zero,
  output logic bus_active_address_line,
  output logic [7:0] status_bus,
  output logic cal_retry,
  output logic cal_use_defaults
);
  localparam int REST_CYC = PERIOD_CYC - 5 * GAP_CYC;
  typedef struct packed {
    logic pf1, pf2, pf3, br1, br2;
    logic pf_pend, cal_pend;
    mrop_pkg::mrop_bld_t bst;
    mrop_pkg::mrop_tx_t tst;
    mrop_pkg::mrop_kind_t kind;
    logic [4:0] bidx, tidx, len, tcnt;
    logic [2:0] pnum, ppkg, seq;
    logic [8:0] cyc;
    logic [20:0] timer;
    logic dr, a1, put, stb;
    logic [7:0] dbus;
    logic tamper_flag, below_starting_current_flag, err, init_phase_indicator;
    logic [2:0] vp;
    logic [5:0][15:0] pv;
    logic [1:0] tries;
    logic retry, defs;
  } mrop_state_t;
  mrop_state_t s, n;
  logic pf_rise, idle, start, push, f_in_ready, f_out_valid, pop;
  logic cal_fail, deliver_fail, defs_set;
  logic [7:0] push_data, f_out_data, stat_w;
  logic [4:0] pidx;

  // Magnitude of a two's complement current sample.
  function automatic logic [15:0] mag(input logic [15:0] c);
    return c[15] ? 16'(~c + 16'h0001) : c;
  endfunction

  // The status byte that goes both on the bus and in the header.
  always_comb begin
    stat_w = 8'h00;
    stat_w[mrop_pkg::ST_TAMPER_FLAG] = s.tamper_flag;
    stat_w[mrop_pkg::ST_BELOW_STARTING_CURRENT_FLAG] = s.below_starting_current_flag;
    stat_w[mrop_pkg::ST_VP1] = s.vp[0];
    stat_w[mrop_pkg::ST_VP2] = s.vp[1];
    stat_w[mrop_pkg::ST_VP3] = s.vp[2];
    stat_w[mrop_pkg::ST_ERR] = s.err;
    stat_w[mrop_pkg::ST_DR] = s.dr;
    stat_w[mrop_pkg::ST_INI] = s.init_phase_indicator;
  end

  mrop_fifo #(
    .W(mrop_pkg::FIFO_W),
    .D(mrop_pkg::FIFO_D)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(push),
    .in_ready(f_in_ready),
    .in_data(push_data),
    .out_valid(f_out_valid),
    .out_ready(pop),
    .out_data(f_out_data)
  );

  // Whole next-state computation: sync, flags, schedule, build, send.
  always_comb begin
    n = s;
    n.put = 1'b0;
    n.retry = 1'b0;
    push = 1'b0;
    push_data = 8'h00;
    pay_ready = 1'b0;
    pop = 1'b0;
    start = 1'b0;
    cal_fail = 1'b0;
    defs_set = 1'b0;
    pidx = s.bidx - mrop_pkg::HDR_BYTES;
    // Pins pass two flops; the third flop only feeds edge detection.
    n.pf1 = supply_break_input;
    n.pf2 = s.pf1;
    n.pf3 = s.pf2;
    n.br1 = bus_ready_stall_input;
    n.br2 = s.br1;
    n.stb = s.put;
    pf_rise = s.pf2 && !s.pf3;
    idle = (s.tst == mrop_pkg::T_IDLE) && (s.bst == mrop_pkg::B_IDLE);
    deliver_fail = (s.tst != mrop_pkg::T_IDLE) &&
                   (s.cyc == mrop_pkg::MAX_PKG_CYC);

    // Tamper, current, voltage and init flags are sampled only between packages so header and bus agree.
    if (idle) begin
      n.tamper_flag = $signed(phase1_curr) <= 0 || $signed(phase2_curr) <= 0 ||
               $signed(phase3_curr) <= 0;
      n.below_starting_current_flag = mag(phase1_curr) < start_level &&
               mag(phase2_curr) < start_level &&
               mag(phase3_curr) < start_level;
      n.vp = {phase3_volt > mrop_pkg::VP_THRESH,
              phase2_volt > mrop_pkg::VP_THRESH,
              phase1_volt > mrop_pkg::VP_THRESH};
      n.init_phase_indicator = !init_active;
      n.pv = {phase3_curr, phase2_curr, phase1_curr,
              phase3_volt, phase2_volt, phase1_volt};
    end

    // Coefficient check: two retries, then defaults and error.
    if (cal_check_done && cal_check_bad) begin
      if (s.tries < mrop_pkg::CAL_RETRIES) begin
        n.retry = 1'b1;
        n.tries = s.tries + 2'h1;
      end else begin
        n.defs = 1'b1;
        defs_set = 1'b1;
        cal_fail = 1'b1;
      end
    end else if (cal_check_done) begin
      n.tries = 2'h0;
    end
    if (cal_timeout) begin
      cal_fail = 1'b1;
    end

    // A new fault wins over a clear in the same cycle.
    n.err = cal_fail || link_fault || internal_fault || deliver_fail ||
            (s.err && !err_clear);

    // Schedule: power fail first, then calibration, then the cycle.
    if (s.timer != 21'h0) begin
      n.timer = s.timer - 21'h1;
    end
    n.pf_pend = pf_rise || s.pf_pend;
    n.cal_pend = cal_request || s.cal_pend;
    if (idle) begin
      if (s.pf_pend) begin
        start = 1'b1;
        n.pf_pend = pf_rise;
        n.kind = mrop_pkg::K_PF;
        n.pnum = mrop_pkg::PKG_PF;
        n.ppkg = mrop_pkg::PKG_E1;
        n.len = mrop_pkg::PF_BYTES;
      end else if (s.cal_pend) begin
        start = 1'b1;
        n.cal_pend = cal_request;
        n.kind = mrop_pkg::K_CAL;
        n.pnum = mrop_pkg::PKG_CAL;
        n.ppkg = mrop_pkg::PKG_CAL;
        n.len = mrop_pkg::HDR_BYTES;
        n.tries = 2'h0;
        n.defs = defs_set; // A mismatch in this same cycle beats the clear.
      end else if (s.timer == 21'h0 && s.init_phase_indicator) begin
        start = 1'b1;
        n.kind = mrop_pkg::K_NORM;
        n.pnum = s.seq;
        n.ppkg = s.seq;
        n.len = mrop_pkg::PKG_BYTES;
        if (s.seq == mrop_pkg::PKG_LAST) begin
          n.seq = mrop_pkg::PKG_FIRST;
          n.timer = 21'(REST_CYC);
        end else begin
          n.seq = s.seq + 3'h1;
          n.timer = 21'(GAP_CYC);
        end
      end
    end
    if (start) begin
      n.bst = mrop_pkg::B_HDR;
      n.bidx = 5'h00;
      n.tst = mrop_pkg::T_RUN;
      n.tidx = 5'h00;
      n.cyc = 9'h000;
      n.dr = 1'b1;
      n.a1 = 1'b1;
      n.tcnt = 5'(mrop_pkg::LEAD_CYC - 1);
    end

    // Builder fills the buffer with header and payload bytes.
    unique case (s.bst)
      mrop_pkg::B_IDLE: begin
      end
      mrop_pkg::B_HDR: begin
        push = 1'b1;
        unique case (s.bidx[1:0])
          2'h0: push_data = {5'h00, s.pnum};
          2'h1: push_data = mrop_pkg::SYNC_BYTE;
          2'h2: push_data = mode_byte;
          2'h3: push_data = stat_w;
        endcase
      end
      mrop_pkg::B_PAY: begin
        if (s.ppkg == mrop_pkg::PKG_LAST) begin
          push = 1'b1;
          push_data = pidx[0] ? s.pv[pidx[4:1]][15:8] :
                      s.pv[pidx[4:1]][7:0];
        end else begin
          push = pay_valid;
          push_data = pay_data;
          pay_ready = f_in_ready;
        end
      end
      default: begin
        n.bst = mrop_pkg::B_IDLE;
      end
    endcase
    if (push && f_in_ready) begin
      n.bidx = s.bidx + 5'h01;
      if (s.bidx == s.len - 5'h01) begin
        n.bst = mrop_pkg::B_IDLE;
      end else if (s.bidx == mrop_pkg::HDR_BYTES - 5'h01) begin
        n.bst = mrop_pkg::B_PAY;
      end
      // The second energy block follows without a new header.
      if (s.kind == mrop_pkg::K_PF &&
          s.bidx == mrop_pkg::PKG_BYTES - 5'h01) begin
        n.ppkg = mrop_pkg::PKG_E2;
      end
    end

    // Sender: one byte per slot, held while the processor stalls.
    if (s.tst != mrop_pkg::T_IDLE && s.cyc != mrop_pkg::MAX_PKG_CYC) begin
      n.cyc = s.cyc + 9'h001;
    end
    unique case (s.tst)
      mrop_pkg::T_IDLE: begin
      end
      mrop_pkg::T_RUN: begin
        if (s.tcnt != 5'h00) begin
          n.tcnt = s.tcnt - 5'h01;
        end else if (f_out_valid && !s.br2) begin
          pop = 1'b1;
          n.put = 1'b1;
          n.dbus = f_out_data;
          n.tidx = s.tidx + 5'h01;
          if (s.tidx == s.len - 5'h01) begin
            n.tst = mrop_pkg::T_TAIL;
            n.tcnt = 5'(mrop_pkg::TAIL_CYC - 1);
          end else if (s.tidx == mrop_pkg::HDR_BYTES - 5'h01) begin
            // Extra slot lets the processor look at the header.
            n.tcnt = 5'(mrop_pkg::SLOT_CYC + mrop_pkg::HDR_GAP_CYC - 1);
          end else if (s.kind == mrop_pkg::K_PF &&
                       s.tidx == mrop_pkg::PKG_BYTES - 5'h01) begin
            n.tcnt = 5'(mrop_pkg::PF_GAP_CYC - 1);
            // Each energy block gets its own time budget.
            n.cyc = 9'h000;
          end else begin
            n.tcnt = 5'(mrop_pkg::SLOT_CYC - 1);
          end
        end
      end
      mrop_pkg::T_TAIL: begin
        if (s.tcnt != 5'h00) begin
          n.tcnt = s.tcnt - 5'h01;
        end else begin
          n.dr = 1'b0;
          n.a1 = 1'b0;
          n.tst = mrop_pkg::T_IDLE;
        end
      end
      default: begin
        n.tst = mrop_pkg::T_IDLE;
      end
    endcase
  end

  // Register all state.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Outputs come straight from the state flops.
  assign pay_pkg = s.ppkg;
  assign data_bus_out = s.dbus;
  assign data_bus_oe = s.a1;
  assign strobe = s.stb; // Rises one cycle after the data settles.
  assign address_line_zero = s.dr;
  assign bus_active_address_line = s.a1;
  assign status_bus = stat_w;
  assign cal_retry = s.retry;
  assign cal_use_defaults = s.defs;

  sequence s_quiet10;
    (!s.br2)[*5] ##1 (!s.br2)[*5];
  endsequence

  a_pkg_number: assert property (@(posedge clk) disable iff (!nrst)
    push && s.bst == mrop_pkg::B_HDR && s.bidx == 5'h00 &&
    s.kind == mrop_pkg::K_NORM |-> push_data <= 8'h05)
    else $error("package number out of range");
  a_cal_number: assert property (@(posedge clk) disable iff (!nrst)
    push && s.bst == mrop_pkg::B_HDR && s.bidx == 5'h00 &&
    s.kind == mrop_pkg::K_CAL |-> push_data == 8'h06)
    else $error("calibration header not six");
  a_pf_number: assert property (@(posedge clk) disable iff (!nrst)
    push && s.bst == mrop_pkg::B_HDR && s.bidx == 5'h00 &&
    s.kind == mrop_pkg::K_PF |-> push_data == 8'h07)
    else $error("power fail header not seven");
  a_sync_byte: assert property (@(posedge clk) disable iff (!nrst)
    push && s.bst == mrop_pkg::B_HDR && s.bidx == 5'h01 |->
    push_data == 8'h80)
    else $error("sync byte wrong");
  a_status_byte: assert property (@(posedge clk) disable iff (!nrst)
    push && s.bst == mrop_pkg::B_HDR && s.bidx == 5'h03 |->
    push_data == status_bus && status_bus[mrop_pkg::ST_DR])
    else $error("status byte differs from bus");
  a_ready_address_line_zero: assert property (@(posedge clk) disable iff (!nrst)
    $rose(status_bus[mrop_pkg::ST_DR]) |-> address_line_zero &&
    bus_active_address_line)
    else $error("ready pulse without address lines");
  a_lead_time: assert property (@(posedge clk) disable iff (!nrst)
    $rose(s.dr) ##1 s_quiet10 |-> ##1 s.put)
    else $error("first byte not 11 clocks after ready");
  a_tail_time: assert property (@(posedge clk) disable iff (!nrst)
    $fell(s.dr) |-> $past(s.put, 12) && s.tidx == s.len)
    else $error("ready not dropped 12 after last byte");
  a_slot_gap: assert property (@(posedge clk) disable iff (!nrst)
    s.put && s.tidx > 5'h04 && s.tidx < s.len &&
    s.ppkg == mrop_pkg::PKG_LAST ##1 s_quiet10 |-> ##1 s.put)
    else $error("measurement byte not on 11th clock");
  a_bus_active_address_line_hold: assert property (@(posedge clk) disable iff (!nrst)
    s.put || strobe |-> bus_active_address_line && data_bus_oe)
    else $error("address line one low during transfer");
  a_stall_hold: assert property (@(posedge clk) disable iff (!nrst)
    s.br2 |=> !s.put)
    else $error("byte sent while stalled");
  a_pf_start: assert property (@(posedge clk) disable iff (!nrst)
    pf_rise && idle && s.timer != 21'h0 && !s.cal_pend |->
    ##2 s.dr && s.kind == mrop_pkg::K_PF)
    else $error("power fail transfer not started");
  a_pf_gap: assert property (@(posedge clk) disable iff (!nrst)
    s.put && s.kind == mrop_pkg::K_PF && s.tidx == 5'h10 |=>
    (!s.put)[*8] ##1 (!s.put)[*7])
    else $error("block gap shorter than 16 clocks");
  a_err_set: assert property (@(posedge clk) disable iff (!nrst)
    link_fault || internal_fault || cal_timeout |=>
    status_bus[mrop_pkg::ST_ERR])
    else $error("error flag not raised");
  a_cal_retry: assert property (@(posedge clk) disable iff (!nrst)
    cal_check_done && cal_check_bad && s.tries == 2'h2 |=>
    cal_use_defaults && !cal_retry && status_bus[mrop_pkg::ST_ERR])
    else $error("third mismatch not handled");
endmodule

// *** sim/mrop_proc_model.sv ***
`timescale 1ns/1ns
module mrop_proc_model (
  input wire logic clk,
  input wire logic strobe,
  input wire logic address_line_zero,
  input wire logic [7:0] data_bus_out,
  input wire logic stall_en,
  output logic bus_ready_stall_input
);
  logic [7:0] rx_q[$];
  int hold;
  int budget;
  initial begin
    bus_ready_stall_input = 1'b0;
    hold = 0;
    budget = 0;
  end
  // The processor only reads the bus, so it never drives the data pins.
  // Stalls are rationed so a package stays well under 300 cycles.
  always @(posedge clk) begin
    if (strobe) rx_q.push_back(data_bus_out);
    if (!address_line_zero) begin
      budget = 3;
      hold = 0;
    end else if (strobe && stall_en && budget > 0) begin
      hold = 14;
      budget--;
    end else if (hold > 0) begin
      hold--;
    end
    #1 bus_ready_stall_input <= (hold > 0) && address_line_zero;
  end
endmodule

// *** sim/meter_result_output_port_tb.sv ***
`timescale 1ns/1ns
module meter_result_output_port_tb;
  logic clk, nrst, supply_break_input, bus_ready_stall_input, init_active;
  logic [7:0] mode_byte, pay_data, data_bus_out, status_bus, stat_seen, ex;
  logic [15:0] v1, v2, v3, i1, i2, i3, start_level;
  logic link_fault, internal_fault, err_clear, cal_request, cal_timeout;
  logic cal_check_done, cal_check_bad, pay_valid, pay_ready, stall_en;
  logic [2:0] pay_pkg, pkg_seen;
  logic data_bus_oe, strobe, address_line_zero, bus_active_address_line;
  logic cal_retry, cal_use_defaults;
  int err_count, check_count, seed, len, bad, w, k, p;
  int st_q[$];
  logic [7:0] pq[$];
  mrop_top #(.PERIOD_CYC(4000), .GAP_CYC(400)) dut (
    .clk(clk), .nrst(nrst), .supply_break_input(supply_break_input),
    .bus_ready_stall_input(bus_ready_stall_input),
    .init_active(init_active), .mode_byte(mode_byte),
    .phase1_volt(v1), .phase2_volt(v2), .phase3_volt(v3),
    .phase1_curr(i1), .phase2_curr(i2), .phase3_curr(i3),
    .start_level(start_level), .link_fault(link_fault),
    .internal_fault(internal_fault), .err_clear(err_clear),
    .cal_request(cal_request), .cal_check_done(cal_check_done),
    .cal_check_bad(cal_check_bad), .cal_timeout(cal_timeout),
    .pay_valid(pay_valid), .pay_data(pay_data), .pay_ready(pay_ready),
    .pay_pkg(pay_pkg), .data_bus_out(data_bus_out),
    .data_bus_oe(data_bus_oe), .strobe(strobe),
    .address_line_zero(address_line_zero),
    .bus_active_address_line(bus_active_address_line),
    .status_bus(status_bus), .cal_retry(cal_retry),
    .cal_use_defaults(cal_use_defaults));
  mrop_proc_model pm (
    .clk(clk), .strobe(strobe), .address_line_zero(address_line_zero),
    .data_bus_out(data_bus_out), .stall_en(stall_en),
    .bus_ready_stall_input(bus_ready_stall_input));
  // Free-running 10 MHz clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Payload source offers a byte every cycle and logs each accepted one.
  always @(posedge clk) begin
    if (pay_valid && pay_ready) begin
      pq.push_back(pay_data);
      #1 pay_data <= $random(seed);
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    check_count++;
    if (seen !== e) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", nm, e, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Cycle at which byte k is strobed, counted from the ready edge.
  function int exp_t(input int k);
    if (k < 4) return 12 + 11 * k;
    if (k < 16) return 67 + 11 * (k - 4);
    return 204 + 11 * (k - 16);
  endfunction
  // Tamper, starting current and the three voltage flags.
  // Starting current compares magnitudes, so a reversed phase still counts.
  function logic [4:0] exp_flags();
    logic [15:0] m1, m2, m3;
    m1 = i1[15] ? 16'(-i1) : i1;
    m2 = i2[15] ? 16'(-i2) : i2;
    m3 = i3[15] ? 16'(-i3) : i3;
    exp_flags[4] = $signed(i1) <= 0 || $signed(i2) <= 0 || $signed(i3) <= 0;
    exp_flags[3] = m1 < start_level && m2 < start_level &&
      m3 < start_level;
    exp_flags[2:0] = {v1 > mrop_pkg::VP_THRESH, v2 > mrop_pkg::VP_THRESH,
      v3 > mrop_pkg::VP_THRESH};
  endfunction
  // Waits for one transfer, timing every strobe and the ready window.
  task xfer(input int n);
    pm.rx_q.delete();
    st_q.delete();
    pq.delete();
    bad = 0;
    w = 0;
    while (address_line_zero !== 1'b1 && w < 5000) begin
      tick(1);
      w++;
    end
    len = 0;
    while (address_line_zero === 1'b1 && len < 400) begin
      tick(1);
      len++;
      if (strobe === 1'b1) st_q.push_back(len);
      if (len == 5) {stat_seen, pkg_seen} = {status_bus, pay_pkg};
      if (status_bus[1] !== address_line_zero) bad++;
      if (bus_active_address_line !== address_line_zero) bad++;
      if (data_bus_oe !== address_line_zero) bad++;
    end
    chk("ready seen", w < 5000, 1);
    chk("line agreement", bad, 0);
    chk("byte count", pm.rx_q.size(), n);
    chk("strobe count", st_q.size(), n);
  endtask
  // Main sequence.
  initial begin
    seed = 32'h5f353b5b;
    nrst = 1'b0;
    {supply_break_input, link_fault, internal_fault, err_clear} = 4'h0;
    {cal_request, cal_check_done, cal_check_bad, cal_timeout} = 4'h0;
    {pay_valid, stall_en, init_active} = 3'b001;
    err_count = 0;
    check_count = 0;
    mode_byte = $random(seed);
    pay_data = $random(seed);
    start_level = 16'h0100;
    v1 = mrop_pkg::VP_THRESH + 16'h0001;
    v2 = $random(seed) | 16'h4000;
    v3 = $random(seed) | 16'h4000;
    {i1, i2, i3} = {16'h0234, 16'h0456, 16'h0678};
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    chk("reset status", status_bus, 8'h00);
    tick(3);
    chk("init flag", status_bus[0], 1'b0);
    init_active = 1'b0;
    pay_valid = 1'b1;
    tick(1);
    chk("init flag", status_bus[0], 1'b1);
    for (p = 0; p < 6; p++) begin
      stall_en = (p == 2);
      xfer(16);
      chk("pkg number", pm.rx_q[0], p);
      chk("pay package", pkg_seen, p);
      chk("sync byte", pm.rx_q[1], mrop_pkg::SYNC_BYTE);
      chk("mode", pm.rx_q[2], mode_byte);
      chk("status byte", pm.rx_q[3], stat_seen);
      chk("status", stat_seen, {exp_flags(), 3'b011});
      for (k = 4; k < 16; k++) begin
        ex = (k[0] == 1'b0) ? 8'h00 : 8'h00;
        case (k / 2)
          2: ex = k[0] ? v1[15:8] : v1[7:0];
          3: ex = k[0] ? v2[15:8] : v2[7:0];
          4: ex = k[0] ? v3[15:8] : v3[7:0];
          5: ex = k[0] ? i1[15:8] : i1[7:0];
          6: ex = k[0] ? i2[15:8] : i2[7:0];
          default: ex = k[0] ? i3[15:8] : i3[7:0];
        endcase
        if (p < 5) ex = pq[k-4];
        chk("payload", pm.rx_q[k], ex);
      end
      if (p == 2) begin
        chk("stalled length", len > 199 && len < 300, 1);
      end else begin
        for (k = 0; k < 16; k++) chk("slot", st_q[k], exp_t(k));
        chk("length", len, 199);
      end
      $display("test package %0d done", p);
    end
    stall_en = 1'b0;
    cal_request = 1'b1;
    tick(1);
    cal_request = 1'b0;
    xfer(4);
    chk("cal number", pm.rx_q[0], mrop_pkg::PKG_CAL);
    chk("cal package", pkg_seen, mrop_pkg::PKG_CAL);
    chk("cal length", len, exp_t(3) + 11);
    $display("test calibration header done");
    supply_break_input = 1'b1;
    xfer(28);
    supply_break_input = 1'b0;
    chk("pf delay", w < 8, 1);
    chk("pf number", pm.rx_q[0], mrop_pkg::PKG_PF);
    chk("pf first block", pkg_seen, mrop_pkg::PKG_E1);
    chk("pf second block", pay_pkg, mrop_pkg::PKG_E2);
    chk("pf no error", status_bus[2], 1'b0);
    for (k = 4; k < 28; k++) chk("pf payload", pm.rx_q[k], pq[k-4]);
    for (k = 0; k < 28; k++) chk("pf slot", st_q[k], exp_t(k));
    chk("pf length", len, exp_t(27) + 11);
    $display("test power fail done");
    for (k = 0; k < 8; k++) begin
      v1 = (k == 0) ? mrop_pkg::VP_THRESH : $random(seed);
      v2 = (k == 1) ? mrop_pkg::VP_THRESH - 16'h0001 : $random(seed);
      v3 = $random(seed);
      start_level = $random(seed) & 16'h0FFF;
      i1 = $random(seed) & 16'h0FFF;
      i2 = k[0] ? -($random(seed) & 16'h00FF) : $random(seed) & 16'h0FFF;
      i3 = (k == 2) ? 16'h0000 : $random(seed) & 16'h0FFF;
      tick(4);
      chk("tamper", status_bus[7], exp_flags() >> 4);
      chk("flags", status_bus[7:3], exp_flags());
    end
    $display("test status flags done");
    for (k = 0; k < 3; k++) begin
      {link_fault, internal_fault, cal_timeout} = 3'b100 >> k;
      tick(1);
      {link_fault, internal_fault, cal_timeout} = 3'b000;
      tick(2);
      chk("error set", status_bus[2], 1'b1);
      err_clear = 1'b1;
      tick(1);
      err_clear = 1'b0;
      tick(1);
      chk("error clear", status_bus[2], 1'b0);
    end
    for (k = 0; k < 3; k++) begin
      {cal_check_done, cal_check_bad} = 2'b11;
      tick(1);
      {cal_check_done, cal_check_bad} = 2'b00;
      chk("retry", cal_retry, k < 2);
      tick(2);
    end
    chk("defaults", cal_use_defaults, 1'b1);
    chk("cal error", status_bus[2], 1'b1);
    $display("test errors done");
    end_sim;
  end
  // Watchdog sized well past the expected run length.
  initial begin
    #(100 * 20000);
    err_count++;
    end_sim;
  end
endmodule
